/* File: mtc_pkg.sv */
// How it works
// - with relative mode on, each result is raw reading minus preset offset
// - the clear command sets the preset offset to zero
// - the capture command loads the latest raw reading as preset offset
// - after reset the mode is automatic and triggering runs continuously
// - interval minimum and default follow speed 8/50/400 ms, maximum 2000 ms
// - each trigger waits the programmed interval before sampling starts
// - the interval returns to its default at every reset
// - stability looks at the current result and the three before it
// - hold freezes the display when max minus min is within range times reading
// - hold range is one of 0.01%, 0.1%, 1% or 10%
// - while hold is active the DC input resistance is forced to 10M
// - each single trigger takes sample count samples, 1 to 1000, default 1
// - a single command makes one trigger at once
// - a second run command in automatic mode stops and holds a stable reading
// - external trigger is rising, falling, high level or low level sensitive
// - in external mode run and single commands are ignored
// - in external mode each finished acquisition emits an output pulse
// - in external mode a failed limit test also emits an output pulse
// - the output pulse has programmable polarity and width
package mtc_pkg;
	// clock and time base
	localparam int unsigned MTC_CLK_PERIOD_NS = 8;
	localparam int unsigned MTC_NS_PER_MS = 1000000;
	localparam int unsigned MTC_CYC_PER_MS = MTC_NS_PER_MS / MTC_CLK_PERIOD_NS;
	// interval limits in ms
	localparam logic [10:0] MTC_IVL_FAST_MS = 11'h008;
	localparam logic [10:0] MTC_IVL_MID_MS = 11'h032;
	localparam logic [10:0] MTC_IVL_SLOW_MS = 11'h190;
	localparam logic [10:0] MTC_IVL_MAX_MS = 11'h7D0;
	// sample count limits
	localparam logic [9:0] MTC_CNT_MIN = 10'h001;
	localparam logic [9:0] MTC_CNT_MAX = 10'h3E8;
	localparam logic [9:0] MTC_CNT_RST = 10'h001;
	// pulse width in clock cycles
	localparam logic [15:0] MTC_WIDTH_RST = 16'h007D;
	// hold range divisors: 10000, 1000, 100, 10
	localparam logic [13:0] MTC_DIV_R0 = 14'h2710;
	localparam logic [13:0] MTC_DIV_R1 = 14'h03E8;
	localparam logic [13:0] MTC_DIV_R2 = 14'h0064;
	localparam logic [13:0] MTC_DIV_R3 = 14'h000A;
	// register offsets
	localparam logic [2:0] MTC_REG_CTRL = 3'h0;
	localparam logic [2:0] MTC_REG_CMD = 3'h1;
	localparam logic [2:0] MTC_REG_IVL = 3'h2;
	localparam logic [2:0] MTC_REG_CNT = 3'h3;
	localparam logic [2:0] MTC_REG_WIDTH = 3'h4;
	localparam logic [2:0] MTC_REG_OFFSET = 3'h5;
	localparam logic [2:0] MTC_REG_READING = 3'h6;
	localparam logic [2:0] MTC_REG_STATUS = 3'h7;
	// command bit positions
	localparam int MTC_CMD_RUN = 0;
	localparam int MTC_CMD_SINGLE = 1;
	localparam int MTC_CMD_CLEAR = 2;
	localparam int MTC_CMD_CAPTURE = 3;
	// trigger modes, speeds and external conditions
	localparam logic [1:0] MTC_AUTO = 2'h0;
	localparam logic [1:0] MTC_SINGLE = 2'h1;
	localparam logic [1:0] MTC_EXT = 2'h2;
	localparam logic [1:0] MTC_FAST = 2'h0;
	localparam logic [1:0] MTC_MID = 2'h1;
	localparam logic [1:0] MTC_RISE = 2'h0;
	localparam logic [1:0] MTC_FALL = 2'h1;
	localparam logic [1:0] MTC_TRIGGER_ON_HIGH_LEVEL = 2'h2;
	localparam logic [1:0] MTC_TRIGGER_ON_LOW_LEVEL = 2'h3;

	typedef struct packed {
		logic hiz_user;
		logic pol_neg;
		logic [1:0] ext_cond;
		logic relative_offset_mode;
		logic [1:0] hold_range;
		logic hold_en;
		logic [1:0] speed;
		logic [1:0] mode;
	} mtc_ctrl_t;
	// slow speed, automatic mode, all else off
	localparam mtc_ctrl_t MTC_CTRL_RST = 12'h008;

	typedef struct packed {
		logic done;
		logic fail;
		logic signed [31:0] value;
	} mtc_sample_t;

	typedef enum logic [1:0] {S_IDLE, S_DELAY, S_ACQ} mtc_state_t;

	function automatic logic [10:0] mtc_ivl_min(input logic [1:0] speed);
		case (speed)
			MTC_FAST: return MTC_IVL_FAST_MS;
			MTC_MID: return MTC_IVL_MID_MS;
			default: return MTC_IVL_SLOW_MS;
		endcase
	endfunction : mtc_ivl_min

	function automatic logic signed [31:0] mtc_max2(input logic signed [31:0] a, input logic signed [31:0] b);
		return (a > b) ? a : b;
	endfunction : mtc_max2

	function automatic logic signed [31:0] mtc_min2(input logic signed [31:0] a, input logic signed [31:0] b);
		return (a < b) ? a : b;
	endfunction : mtc_min2
endpackage : mtc_pkg

/* File: mtc_trigger_ctrl.sv */
// Added by the designer: the plain strobed port and the register offsets.
module mtc_trigger_ctrl
	import mtc_pkg::*;
#(
	parameter int unsigned CYC_PER_MS = MTC_CYC_PER_MS
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// register port
	input wire logic [2:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// measurement engine
	output logic sample_start_out,
	input wire mtc_sample_t sample_in,
	// external trigger and completion pulse
	input wire logic ext_trig_in,
	output logic completion_pulse_output_out,
	// display and front end
	output logic [31:0] reading_out,
	output logic reading_valid_out,
	output logic dcv_hiz_sel_out
);

	mtc_ctrl_t ctrl_ff;
	mtc_ctrl_t new_ctrl;
	mtc_state_t state_ff;
	logic [10:0] ivl_ff;
	logic [9:0] count_ff;
	logic [15:0] width_ff;
	logic signed [31:0] offset_ff;
	logic signed [31:0] last_raw_ff;
	logic signed [31:0] win_ff [0:2];
	logic [1:0] fill_ff;
	logic running_ff;
	logic stop_req_ff;
	logic held_ff;
	logic [16:0] div_ff;
	logic [10:0] ms_ff;
	logic [9:0] left_ff;
	logic start_ff;
	logic ext_s1_ff;
	logic ext_s2_ff;
	logic ext_s3_ff;
	logic [15:0] pulse_cnt_ff;
	logic pulse_out_ff;
	logic [31:0] rdata_ff;
	logic [31:0] disp_ff;
	logic disp_vld_ff;
	logic hiz_ff;
	logic wr_ctrl;
	logic wr_cmd;
	logic run_cmd;
	logic single_cmd;
	logic ext_hit;
	logic trig;
	logic tick;
	logic ms_done;
	logic done_acq;
	logic stable_now;
	logic pulse_go;
	logic signed [31:0] result;

	// true when the spread of four results is within range times reading
	function automatic logic mtc_stable(input logic signed [31:0] r0, input logic signed [31:0] r1,
		input logic signed [31:0] r2, input logic signed [31:0] r3, input logic [1:0] rng);
		logic signed [31:0] mx;
		logic signed [31:0] mn;
		logic [32:0] diff;
		logic [32:0] mag;
		logic [13:0] div;
		logic [46:0] lhs;
		mx = mtc_max2(mtc_max2(r0, r1), mtc_max2(r2, r3));
		mn = mtc_min2(mtc_min2(r0, r1), mtc_min2(r2, r3));
		diff = {mx[31], mx} - {mn[31], mn};
		mag = r0[31] ? (33'h0 - {r0[31], r0}) : {1'b0, r0};
		// divide range out as a multiply so no divider is needed
		case (rng)
			2'h0: div = MTC_DIV_R0;
			2'h1: div = MTC_DIV_R1;
			2'h2: div = MTC_DIV_R2;
			default: div = MTC_DIV_R3;
		endcase
		lhs = 47'(diff) * 47'(div);
		return lhs <= 47'(mag);
	endfunction : mtc_stable

	// command decode
	assign new_ctrl = mtc_ctrl_t'(reg_wdata_in[$bits(mtc_ctrl_t)-1:0]);
	assign wr_ctrl = reg_wr_in && (reg_addr_in == MTC_REG_CTRL);
	assign wr_cmd = reg_wr_in && (reg_addr_in == MTC_REG_CMD);
	assign run_cmd = wr_cmd && reg_wdata_in[MTC_CMD_RUN] && (ctrl_ff.mode == MTC_AUTO);
	assign single_cmd = wr_cmd && reg_wdata_in[MTC_CMD_SINGLE] && (ctrl_ff.mode == MTC_SINGLE);

	// external trigger synchroniser, stage one feeds only stage two
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			ext_s1_ff <= 1'b0;
			ext_s2_ff <= 1'b0;
			ext_s3_ff <= 1'b0;
		end else begin
			ext_s1_ff <= ext_trig_in;
			ext_s2_ff <= ext_s1_ff;
			ext_s3_ff <= ext_s2_ff;
		end
	end

	// external condition on the synchronised level
	always_comb begin
		case (ctrl_ff.ext_cond)
			MTC_RISE: ext_hit = ext_s2_ff && !ext_s3_ff;
			MTC_FALL: ext_hit = !ext_s2_ff && ext_s3_ff;
			MTC_TRIGGER_ON_HIGH_LEVEL: ext_hit = ext_s2_ff;
			default: ext_hit = !ext_s2_ff;
		endcase
	end

	// trigger sources; a trigger arriving while busy is dropped
	always_comb begin
		trig = 1'b0;
		if (state_ff == S_IDLE) begin
			case (ctrl_ff.mode)
				MTC_AUTO: trig = running_ff;
				MTC_SINGLE: trig = single_cmd;
				MTC_EXT: trig = ext_hit;
				default: trig = 1'b0;
			endcase
		end
	end

	assign tick = (div_ff == 17'(CYC_PER_MS - 1));
	assign ms_done = (ms_ff == ivl_ff);
	assign done_acq = (state_ff == S_ACQ) && sample_in.done;
	assign result = ctrl_ff.relative_offset_mode ? (sample_in.value - offset_ff) : sample_in.value;
	assign stable_now = done_acq && (fill_ff == 2'h3) &&
		mtc_stable(result, win_ff[0], win_ff[1], win_ff[2], ctrl_ff.hold_range);

	// acquisition sequencer: delay in ms ticks, then sample_count samples in single mode, one sample in the other modes
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			state_ff <= S_IDLE;
			div_ff <= 17'h0;
			ms_ff <= 11'h0;
			left_ff <= 10'h0;
			start_ff <= 1'b0;
		end else begin
			start_ff <= 1'b0;
			unique case (state_ff)
				S_IDLE: begin
					if (trig) begin
						state_ff <= S_DELAY;
						div_ff <= 17'h0;
						ms_ff <= 11'h0;
						left_ff <= (ctrl_ff.mode == MTC_SINGLE) ? count_ff : 10'h001;
					end
				end
				S_DELAY: begin
					if (ms_done) begin
						state_ff <= S_ACQ;
						start_ff <= 1'b1;
					end else if (tick) begin
						div_ff <= 17'h0;
						ms_ff <= ms_ff + 11'h1;
					end else begin
						div_ff <= div_ff + 17'h1;
					end
				end
				S_ACQ: begin
					if (sample_in.done) begin
						if (left_ff <= 10'h001) begin
							state_ff <= S_IDLE;
						end else begin
							left_ff <= left_ff - 10'h1;
							start_ff <= 1'b1;
						end
					end
				end
			endcase
		end
	end

	// configuration registers; interval and count are kept within limits
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			ctrl_ff <= MTC_CTRL_RST;
			ivl_ff <= MTC_IVL_SLOW_MS;
			count_ff <= MTC_CNT_RST;
			width_ff <= MTC_WIDTH_RST;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				MTC_REG_CTRL: begin
					ctrl_ff <= new_ctrl;
					if (new_ctrl.speed != ctrl_ff.speed) begin
						ivl_ff <= mtc_ivl_min(new_ctrl.speed);
					end
				end
				MTC_REG_IVL: begin
					if ((|reg_wdata_in[31:11]) || (reg_wdata_in[10:0] > MTC_IVL_MAX_MS)) begin
						ivl_ff <= MTC_IVL_MAX_MS;
					end else if (reg_wdata_in[10:0] < mtc_ivl_min(ctrl_ff.speed)) begin
						ivl_ff <= mtc_ivl_min(ctrl_ff.speed);
					end else begin
						ivl_ff <= reg_wdata_in[10:0];
					end
				end
				MTC_REG_CNT: begin
					if ((|reg_wdata_in[31:10]) || (reg_wdata_in[9:0] > MTC_CNT_MAX)) begin
						count_ff <= MTC_CNT_MAX;
					end else if (reg_wdata_in[9:0] < MTC_CNT_MIN) begin
						count_ff <= MTC_CNT_MIN;
					end else begin
						count_ff <= reg_wdata_in[9:0];
					end
				end
				MTC_REG_WIDTH: width_ff <= (reg_wdata_in[15:0] == 16'h0) ? 16'h0001 : reg_wdata_in[15:0];
				default: ;
			endcase
		end
	end

	// preset offset: direct write, clear wins over capture
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			offset_ff <= 32'h0;
		end else if (wr_cmd && reg_wdata_in[MTC_CMD_CLEAR]) begin
			offset_ff <= 32'h0;
		end else if (wr_cmd && reg_wdata_in[MTC_CMD_CAPTURE]) begin
			offset_ff <= last_raw_ff;
		end else if (reg_wr_in && (reg_addr_in == MTC_REG_OFFSET)) begin
			offset_ff <= reg_wdata_in;
		end
	end

	// reading window of the three previous results
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			last_raw_ff <= 32'h0;
			win_ff[0] <= 32'h0;
			win_ff[1] <= 32'h0;
			win_ff[2] <= 32'h0;
			fill_ff <= 2'h0;
		end else if (done_acq) begin
			last_raw_ff <= sample_in.value;
			win_ff[0] <= result;
			win_ff[1] <= win_ff[0];
			win_ff[2] <= win_ff[1];
			if (fill_ff != 2'h3) begin
				fill_ff <= fill_ff + 2'h1;
			end
		end
	end

	// continuous run state; a second run asks to stop on a stable reading
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			running_ff <= 1'b1;
			stop_req_ff <= 1'b0;
		end else if (wr_ctrl && (new_ctrl.mode != ctrl_ff.mode)) begin
			running_ff <= (new_ctrl.mode == MTC_AUTO);
			stop_req_ff <= 1'b0;
		end else if (run_cmd) begin
			running_ff <= 1'b1;
			stop_req_ff <= running_ff && !stop_req_ff;
		end else if (stop_req_ff && stable_now) begin
			running_ff <= 1'b0;
			stop_req_ff <= 1'b0;
		end
	end

	// hold flag freezes the display; the stable reading itself is shown
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			held_ff <= 1'b0;
		end else if (stable_now && (ctrl_ff.hold_en || stop_req_ff)) begin
			held_ff <= 1'b1;
		end else if (run_cmd || (wr_ctrl && !new_ctrl.hold_en)) begin
			held_ff <= 1'b0;
		end
	end

	// display register
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			disp_ff <= 32'h0;
			disp_vld_ff <= 1'b0;
		end else begin
			disp_vld_ff <= done_acq && !held_ff;
			if (done_acq && !held_ff) begin
				disp_ff <= result;
			end
		end
	end

	// input resistance: hold overrides the user choice to avoid noise
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			hiz_ff <= 1'b0;
		end else begin
			hiz_ff <= ctrl_ff.hiz_user && !(ctrl_ff.hold_en || held_ff);
		end
	end

	// completion pulse; a new event restarts the width count
	assign pulse_go = (ctrl_ff.mode == MTC_EXT) && (done_acq || sample_in.fail);
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			pulse_cnt_ff <= 16'h0;
			pulse_out_ff <= 1'b0;
		end else begin
			if (pulse_go) begin
				pulse_cnt_ff <= width_ff;
			end else if (pulse_cnt_ff != 16'h0) begin
				pulse_cnt_ff <= pulse_cnt_ff - 16'h1;
			end
			pulse_out_ff <= ctrl_ff.pol_neg ^ (pulse_go || (pulse_cnt_ff > 16'h0001));
		end
	end

	// register read, data valid one cycle after the strobe
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			rdata_ff <= 32'h0;
		end else begin
			rdata_ff <= 32'h0;
			if (reg_rd_in) begin
				case (reg_addr_in)
					MTC_REG_CTRL: rdata_ff <= 32'(ctrl_ff);
					MTC_REG_IVL: rdata_ff <= 32'(ivl_ff);
					MTC_REG_CNT: rdata_ff <= 32'(count_ff);
					MTC_REG_WIDTH: rdata_ff <= 32'(width_ff);
					MTC_REG_OFFSET: rdata_ff <= offset_ff;
					MTC_REG_READING: rdata_ff <= disp_ff;
					MTC_REG_STATUS: rdata_ff <= {28'h0, (state_ff != S_IDLE), held_ff, stop_req_ff, running_ff};
					default: rdata_ff <= 32'h0;
				endcase
			end
		end
	end

	assign reg_rdata_out = rdata_ff;
	assign sample_start_out = start_ff;
	assign completion_pulse_output_out = pulse_out_ff;
	assign reading_out = disp_ff;
	assign reading_valid_out = disp_vld_ff;
	assign dcv_hiz_sel_out = hiz_ff;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	a_auto_after_reset: assert property ($fell(rst_in) |-> running_ff && ctrl_ff.mode == MTC_AUTO)
		else $error("not automatic and running after reset");
	a_rel_subtract: assert property (done_acq && !held_ff && ctrl_ff.relative_offset_mode
		|=> reading_out == 32'($past(sample_in.value) - $past(offset_ff)))
		else $error("relative result is not raw minus offset");
	a_offset_clear: assert property (wr_cmd && reg_wdata_in[MTC_CMD_CLEAR] |=> offset_ff == 32'h0)
		else $error("offset not cleared");
	a_offset_capture: assert property (wr_cmd && reg_wdata_in[MTC_CMD_CAPTURE] && !reg_wdata_in[MTC_CMD_CLEAR]
		|=> offset_ff == $past(last_raw_ff))
		else $error("offset capture lost the last reading");
	a_ivl_limits: assert property (ivl_ff >= mtc_ivl_min(ctrl_ff.speed) && ivl_ff <= MTC_IVL_MAX_MS)
		else $error("interval outside its limits");
	a_delay_start: assert property (sample_start_out && $past(state_ff) == S_DELAY |-> $past(ms_ff) == $past(ivl_ff))
		else $error("sample started before the interval ran out");
	a_hold_freeze: assert property (held_ff && !run_cmd |=> $stable(reading_out))
		else $error("display changed while held");
	a_hiz_forced: assert property (ctrl_ff.hold_en |=> !dcv_hiz_sel_out)
		else $error("high input resistance chosen during hold");
	a_count_limits: assert property (count_ff >= MTC_CNT_MIN && count_ff <= MTC_CNT_MAX)
		else $error("sample count outside its limits");
	a_ext_start: assert property (ctrl_ff.mode == MTC_EXT && state_ff == S_IDLE && ext_hit |=> state_ff == S_DELAY)
		else $error("external trigger not taken");
	a_ext_no_single: assert property (ctrl_ff.mode == MTC_EXT && state_ff == S_IDLE && !ext_hit
		|=> state_ff == S_IDLE)
		else $error("trigger started without the external condition");
	a_pulse_active: assert property (pulse_go |=> completion_pulse_output_out != $past(ctrl_ff.pol_neg))
		else $error("completion pulse missing");

	c_auto_stop: cover property (run_cmd && running_ff ##[1:1000] !running_ff);
	c_single_multi: cover property (single_cmd && count_ff > 10'h001 ##[1:1000] sample_start_out);
	c_ext_pulse: cover property (pulse_go ##1 completion_pulse_output_out != ctrl_ff.pol_neg);
endmodule : mtc_trigger_ctrl

/* File: mtc_meas_model.sv */
module mtc_meas_model
	import mtc_pkg::*;
(
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// behaviour set by the bench
	input wire logic [7:0] lat_in,
	input wire logic signed [31:0] value_in,
	input wire logic fail_in,
	// engine handshake
	input wire logic start_in,
	output mtc_sample_t sample_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] wait_ff;
	logic busy_ff;

	// engine answers lat_in + 2 cycles after start_in; value is only meaningful with done
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			busy_ff <= 1'b0;
			wait_ff <= 9'h000;
			sample_out <= '0;
		end else begin
			sample_out.done <= 1'b0;
			sample_out.fail <= fail_in;
			// toggle value outside done so a stale sample never looks valid
			sample_out.value <= ~sample_out.value;
			if (start_in) begin
				busy_ff <= 1'b1;
				wait_ff <= {1'b0, lat_in};
			end else if (busy_ff && wait_ff == 9'h000) begin
				busy_ff <= 1'b0;
				sample_out.done <= 1'b1;
				sample_out.value <= value_in;
			end else if (busy_ff) begin
				wait_ff <= wait_ff - 9'h001;
			end
		end
	end
endmodule : mtc_meas_model

/* File: tb_top.sv */
module tb_top
	import mtc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CPM = 2;
	logic core_clk_in, rst_in, reg_wr_in, reg_rd_in, ext_trig_in, fail_q, pol_q, jit_q;
	logic [2:0] reg_addr_in;
	logic [31:0] reg_wdata_in, reg_rdata_out, reading_out, rd_val;
	logic sample_start_out, completion_pulse_output_out, reading_valid_out, dcv_hiz_sel_out;
	logic [7:0] lat_q;
	logic signed [31:0] val_q;
	mtc_sample_t sample_in;
	int err_count, checks, cyc, starts, t_start, pul_run, pul_len, pul_cnt, s0, t0, vld_cnt, v0;

	mtc_trigger_ctrl #(.CYC_PER_MS(CPM)) i_dut (
		.core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.sample_start_out(sample_start_out), .sample_in(sample_in), .ext_trig_in(ext_trig_in),
		.completion_pulse_output_out(completion_pulse_output_out), .reading_out(reading_out),
		.reading_valid_out(reading_valid_out), .dcv_hiz_sel_out(dcv_hiz_sel_out));

	// with jitter on, every other sample reads 3 counts high so the four-reading spread is 0.3 percent
	mtc_meas_model i_model (
		.core_clk_in(core_clk_in), .rst_in(rst_in), .lat_in(lat_q),
		.value_in(val_q + ((jit_q && starts[0]) ? 32'sd3 : 32'sd0)), .fail_in(fail_q),
		.start_in(sample_start_out), .sample_out(sample_in));

	initial begin
		core_clk_in = 1'b0;
		forever #4 core_clk_in = ~core_clk_in;
	end

	task automatic stop_test();
		if (err_count == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : stop_test

	// start counter, pulse width meter and hang guard
	always @(posedge core_clk_in) begin
		cyc <= cyc + 1;
		if (sample_start_out === 1'b1) begin
			starts <= starts + 1;
			t_start <= cyc;
		end
		if (reading_valid_out === 1'b1) vld_cnt <= vld_cnt + 1;
		if (completion_pulse_output_out !== pol_q) pul_run <= pul_run + 1;
		else if (pul_run != 0) begin
			pul_len <= pul_run;
			pul_cnt <= pul_cnt + 1;
			pul_run <= 0;
		end
		if (cyc == 20000) begin
			err_count = err_count + 1;
			stop_test();
		end
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge core_clk_in);
		reg_wr_in <= 1'b0;
	endtask : wr

	// data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [31:0] d);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge core_clk_in);
		reg_rd_in <= 1'b0;
		#1 d = reg_rdata_out;
	endtask : rd

	task automatic rchk(input logic [2:0] a, input logic [31:0] exp, input string name);
		rd(a, rd_val);
		chk(name, rd_val, exp);
	endtask : rchk

	task automatic wait_starts(input int n);
		int k;
		k = 0;
		while (starts < n && k < 4000) begin
			@(posedge core_clk_in);
			k++;
		end
		if (k == 4000) err_count++;
	endtask : wait_starts

	// poll a status bit, bounded so a stuck flag ends in a mismatch
	task automatic wait_stat(input int b, input logic v);
		int k;
		k = 0;
		rd(MTC_REG_STATUS, rd_val);
		while (rd_val[b] !== v && k < 3000) begin
			rd(MTC_REG_STATUS, rd_val);
			k++;
		end
		if (k == 3000) err_count++;
	endtask : wait_stat

	initial begin
		{reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in, ext_trig_in, fail_q, pol_q, jit_q} = '0;
		{err_count, checks, cyc, starts, t_start, pul_run, pul_len, pul_cnt, vld_cnt} = '0;
		rst_in = 1'b1;
		lat_q = 8'h04;
		val_q = 32'h000003E8;
		repeat (2) @(posedge core_clk_in);
		rst_in <= 1'b0;
		// power-on defaults, auto mode already running
		rchk(MTC_REG_CTRL, 32'h00000008, "ctrl_rst");
		rchk(MTC_REG_IVL, 32'h00000190, "ivl_rst");
		rchk(MTC_REG_CNT, 32'h00000001, "cnt_rst");
		rchk(MTC_REG_OFFSET, 32'h00000000, "ofs_rst");
		rchk(MTC_REG_STATUS, 32'h00000009, "stat_rst");
		wait_starts(1);
		chk("auto_wait", 32'(t_start >= 800), 32'h1);
		// speed change reloads the minimum; writes clamp to the legal span
		wr(MTC_REG_CTRL, 32'h00000005);
		wait_stat(3, 1'b0);
		rchk(MTC_REG_IVL, 32'h00000032, "ivl_mid");
		wr(MTC_REG_IVL, 32'h000007FF);
		rchk(MTC_REG_IVL, 32'h000007D0, "ivl_max");
		wr(MTC_REG_CTRL, 32'h00000001);
		rchk(MTC_REG_IVL, 32'h00000008, "ivl_fast");
		wr(MTC_REG_IVL, 32'h00000003);
		rchk(MTC_REG_IVL, 32'h00000008, "ivl_low");
		wr(MTC_REG_CNT, 32'h00000000);
		rchk(MTC_REG_CNT, 32'h00000001, "cnt_low");
		wr(MTC_REG_CNT, 32'h000007FF);
		rchk(MTC_REG_CNT, 32'h000003E8, "cnt_max");
		// single trigger with three samples
		wr(MTC_REG_CNT, 32'h00000003);
		s0 = starts;
		t0 = cyc;
		v0 = vld_cnt;
		wr(MTC_REG_CMD, 32'h00000002);
		wait_starts(s0 + 1);
		chk("single_wait", 32'(t_start - t0 >= 16 && t_start - t0 <= 34), 32'h1);
		wait_stat(3, 1'b0);
		repeat (60) @(posedge core_clk_in);
		chk("single_cnt", 32'(starts - s0), 32'h3);
		chk("single_vld", 32'(vld_cnt - v0), 32'h3);
		chk("single_rdg", reading_out, 32'h000003E8);
		// relative offset: direct value, clear, capture
		wr(MTC_REG_OFFSET, 32'h00000064);
		wr(MTC_REG_CTRL, 32'h00000081);
		wr(MTC_REG_CMD, 32'h00000002);
		wait_stat(3, 1'b0);
		chk("rel_rdg", reading_out, 32'h00000384);
		wr(MTC_REG_CMD, 32'h00000004);
		rchk(MTC_REG_OFFSET, 32'h00000000, "rel_clr");
		wr(MTC_REG_CMD, 32'h00000008);
		rchk(MTC_REG_OFFSET, 32'h000003E8, "rel_cap");
		wr(MTC_REG_CMD, 32'h00000002);
		wait_stat(3, 1'b0);
		rchk(MTC_REG_READING, 32'h00000000, "rel_zero");
		// external mode: manual sources ignored
		wr(MTC_REG_WIDTH, 32'h00000005);
		wr(MTC_REG_CTRL, 32'h00000002);
		s0 = starts;
		wr(MTC_REG_CMD, 32'h00000003);
		repeat (60) @(posedge core_clk_in);
		chk("ext_manual", 32'(starts - s0), 32'h0);
		// every pin condition, alternating pulse polarity
		for (int c = 0; c < 4; c++) begin
			ext_trig_in <= c[0];
			pol_q <= c[0];
			wr(MTC_REG_CTRL, 32'h00000002 | (32'(c) << 8) | (32'(c[0]) << 10));
			repeat (10) @(posedge core_clk_in);
			chk("pulse_idle", 32'(completion_pulse_output_out), 32'(c[0]));
			s0 = starts;
			ext_trig_in <= ~c[0];
			wait_starts(s0 + 1);
			ext_trig_in <= c[0];
			chk("ext_hit", 32'(starts > s0), 32'h1);
			s0 = pul_cnt;
			wait_stat(3, 1'b0);
			repeat (10) @(posedge core_clk_in);
			chk("done_pulse", 32'(pul_cnt - s0), 32'h1);
			chk("pulse_width", 32'(pul_len), 32'h5);
		end
		// limit failure alone also pulses
		s0 = pul_cnt;
		fail_q <= 1'b1;
		@(posedge core_clk_in);
		fail_q <= 1'b0;
		repeat (12) @(posedge core_clk_in);
		chk("fail_pulse", 32'(pul_cnt - s0), 32'h1);
		// auto mode, second run stops on a stable reading
		pol_q <= 1'b0;
		wr(MTC_REG_CTRL, 32'h00000800);
		repeat (4) @(posedge core_clk_in);
		chk("hiz_user", 32'(dcv_hiz_sel_out), 32'h1);
		wr(MTC_REG_CMD, 32'h00000001);
		wait_stat(2, 1'b1);
		chk("run_hold", {30'h0, rd_val[2], rd_val[0]}, 32'h2);
		chk("hiz_forced", 32'(dcv_hiz_sel_out), 32'h0);
		s0 = starts;
		repeat (100) @(posedge core_clk_in);
		chk("stopped", 32'(starts - s0), 32'h0);
		// restart with jitter; window fills before hold is armed, 0.1% must not hold, 10% must
		wr(MTC_REG_CMD, 32'h00000001);
		jit_q <= 1'b1;
		repeat (150) @(posedge core_clk_in);
		wr(MTC_REG_CTRL, 32'h00000830);
		repeat (300) @(posedge core_clk_in);
		rd(MTC_REG_STATUS, rd_val);
		chk("hold_tight", 32'(rd_val[2]), 32'h0);
		chk("hold_hiz", 32'(dcv_hiz_sel_out), 32'h0);
		wr(MTC_REG_CTRL, 32'h00000870);
		wait_stat(2, 1'b1);
		chk("hold_rng", 32'(rd_val[2]), 32'h1);
		// second reset in mid-run brings the defaults back
		@(posedge core_clk_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge core_clk_in);
		rst_in <= 1'b0;
		rchk(MTC_REG_IVL, 32'h00000190, "ivl_rst2");
		rchk(MTC_REG_CTRL, 32'h00000008, "ctrl_rst2");
		stop_test();
	end
endmodule : tb_top
